// [inc/lcd_keyscan_pkg.sv]
// Shared constants and types of the display command and key scan logic
package lcd_keyscan_pkg;
  // Core clock and oscillator rates
  localparam int          CLK_PERIOD_NS = 8;
  localparam int          CLK_HZ        = 125000000;
  localparam int          OSC_HZ        = 145000;
  localparam logic [15:0] OSC_DIV       = 16'(CLK_HZ / OSC_HZ);
  // Times as printed, in ns; cycle counts round up (least times)
  localparam int T_PWRUP_NS    = 1500000;
  localparam int T_RSTLOW_NS   = 1200000;
  localparam int T_RSTBUSY_NS  = 250000;
  localparam int T_CLEAR_NS    = 234480;
  localparam int T_WRITE_NS    = 41380;
  localparam int PWRUP_CYC     = (T_PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RSTLOW_CYC    = (T_RSTLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RSTBUSY_CYC   = (T_RSTBUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLEAR_CYC     = (T_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC     = (T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Opcodes in instruction bits 15-8
  localparam logic [7:0] OP_CLEAR    = 8'h99;
  localparam logic [7:0] OP_HOME     = 8'h91;
  localparam logic [7:0] OP_ENTRY    = 8'h88;
  localparam logic [7:0] OP_DISP     = 8'h89;
  localparam logic [7:0] OP_ASHIFT   = 8'h92;
  localparam logic [7:0] OP_DSHIFT   = 8'h8A;
  localparam logic [7:0] OP_PORT     = 8'h8B;
  localparam logic [7:0] OP_CONTRAST = 8'h8C;
  localparam logic [7:0] OP_MODE     = 8'h8E;
  localparam logic [7:0] OP_DDMK     = 8'h93;
  localparam logic [7:0] OP_GLYPH    = 8'h90;
  localparam logic [7:0] OP_WRITE    = 8'h98;
  localparam logic [7:0] OP_KEYREAD  = 8'hA7;
  // Key reply fixed field, memory layout and reset values
  localparam logic [5:0] KEY_FIXED   = 6'h27;
  localparam logic [7:0] SPACE_CODE  = 8'h20;
  localparam logic [7:0] HOME_POS    = 8'h00;
  localparam int         CHAR_CELLS  = 14;
  localparam int         ICON_BIT    = 4;
  localparam int         ICON_W      = 5;
  // Key scan line counts and timing in oscillator ticks
  localparam int SCAN_LINES     = 8;
  localparam int RET_LINES      = 4;
  localparam int SCAN_LOW_TICKS = 4;
  localparam int SAMPLE_TICK    = 3;
  localparam int FRAME_TICKS    = 64;
  localparam int KEY_LOAD_TICKS = 2;
  // APB register byte offsets
  localparam logic [11:0] REG_STATUS = 12'h000;
  localparam logic [11:0] REG_KEY    = 12'h004;
  localparam logic [11:0] REG_OSCDIV = 12'h008;
  localparam logic [11:0] REG_SETUP  = 12'h00C;
  typedef enum logic [1:0] {TGT_CHAR = 2'b00, TGT_ICON = 2'b01, TGT_GLYPH = 2'b11} mem_target_t;
  typedef enum logic [1:0] {SCAN_IDLE = 2'b00, SCAN_RUN = 2'b01, SCAN_LOAD = 2'b11} scan_state_t;
endpackage

// [src/sync2.sv]
// Two-flop synchroniser for a group of asynchronous levels
module sync2 #(
  parameter int W = 1
)(
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
endmodule

// [src/key_scanner.sv]
// Key matrix scanner: drives scan lines, samples returns, holds key code
module key_scanner
  import lcd_keyscan_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  osc_tick,
  input  wire logic                  scan_en,
  input  wire logic                  hold,
  input  wire logic [RET_LINES-1:0]  ret_sync,
  output logic                       scan_window,
  output logic [SCAN_LINES-1:0]      scan_drive_n,
  output logic                       pullup_en,
  output logic                       all_nonselect,
  output logic [7:0]                 key_code,
  output logic                       key_pending
);
  scan_state_t          state_reg;
  logic [5:0]           frame_reg;
  logic [2:0]           line_reg;
  logic [1:0]           sub_reg;
  logic [1:0]           load_reg;
  logic [RET_LINES-1:0] flags_reg;
  logic [2:0]           code_reg;

  // Free-running frame of oscillator ticks; a window opens at zero
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      frame_reg <= '0;
    else if (osc_tick)
      frame_reg <= (frame_reg == 6'(FRAME_TICKS - 1)) ? 6'h00 : frame_reg + 6'h01;

  // Window sequencer; sampling and result load only while enabled
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      state_reg <= SCAN_IDLE;
      line_reg <= '0;
      sub_reg <= '0;
      load_reg <= '0;
      flags_reg <= '0;
      code_reg <= '0;
      key_code <= 8'h00;
      key_pending <= 1'b0;
    end
    else if (osc_tick)
      case (state_reg)
        SCAN_IDLE:
          if (frame_reg == 6'h00)
          begin
            state_reg <= SCAN_RUN;
            line_reg <= '0;
            sub_reg <= '0;
            flags_reg <= '0;
            code_reg <= '0;
          end
        SCAN_RUN:
        begin
          // Sample at the end of the third quarter of the low period
          if (sub_reg == 2'(SAMPLE_TICK - 1) && scan_en && ~&ret_sync)
          begin
            flags_reg <= flags_reg | ~ret_sync;
            code_reg <= line_reg;
          end
          sub_reg <= sub_reg + 2'h1;
          if (sub_reg == 2'(SCAN_LOW_TICKS - 1))
          begin
            sub_reg <= '0;
            line_reg <= line_reg + 3'h1;
            if (line_reg == 3'(SCAN_LINES - 1))
            begin
              state_reg <= SCAN_LOAD;
              load_reg <= '0;
            end
          end
        end
        SCAN_LOAD:
        begin
          load_reg <= load_reg + 2'h1;
          if (load_reg == 2'(KEY_LOAD_TICKS - 1))
          begin
            state_reg <= SCAN_IDLE;
            // Reading in progress freezes the held code
            if (!hold && scan_en)
            begin
              key_code <= {flags_reg, 1'b0, code_reg};
              key_pending <= |flags_reg;
            end
          end
        end
        default:
          state_reg <= SCAN_IDLE;
      endcase

  // Pins registered; scan pulses only inside the window gap
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      scan_window <= 1'b0;
      scan_drive_n <= '1;
      pullup_en <= 1'b0;
      all_nonselect <= 1'b0;
    end
    else
    begin
      scan_window <= state_reg == SCAN_RUN;
      scan_drive_n <= (state_reg == SCAN_RUN && scan_en) ? ~(8'h01 << line_reg) : 8'hFF;
      pullup_en <= state_reg == SCAN_RUN && scan_en;
      all_nonselect <= state_reg == SCAN_RUN && !scan_en;
    end
endmodule

// [src/lcd_command_keyscan.sv]
// Instruction decoder, serial link and key scan top of the display controller
module lcd_command_keyscan
  import lcd_keyscan_pkg::*;
#(
  parameter int PWRUP_CYCLES   = PWRUP_CYC,
  parameter int RSTLOW_CYCLES  = RSTLOW_CYC,
  parameter int RSTBUSY_CYCLES = RSTBUSY_CYC,
  parameter int CLEAR_CYCLES   = CLEAR_CYC,
  parameter int WRITE_CYCLES   = WRITE_CYC,
  parameter int GLYPH_DEPTH    = 256
)(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        link_clk,
  input  wire logic        link_sel_n,
  input  wire logic        link_data_in,
  output logic             link_data_out,
  output logic             link_data_oe,
  input  wire logic        reset_pin_n,
  input  wire logic        mode_select_upper,
  input  wire logic        mode_select_lower,
  input  wire logic [3:0]  key_return_lines,
  output logic             busy_flag,
  output logic             key_pending,
  output logic [7:0]       shared_scan_segment_outputs,
  output logic             key_pullup_en,
  output logic             scan_window,
  output logic             all_segments_nonselect,
  output logic [3:0]       static_port,
  output logic [3:0]       contrast_level,
  output logic             display_on,
  output logic             icon_on,
  output logic             blink_on,
  output logic             power_down
);
  logic [9:0]        sync_q;
  logic              lclk_s;
  logic              sel_n_s;
  logic              din_s;
  logic              rpin_s;
  logic [1:0]        ms_s;
  logic [3:0]        ret_s;
  logic              lclk_d_reg;
  logic              rise;
  logic              fall;
  logic [14:0]       rx_shift_reg;
  logic [3:0]        bit_cnt_reg;
  logic              word_stb_reg;
  logic [7:0]        instruction_holding_reg;
  logic [7:0]        data_holding_reg;
  logic [15:0]       tx_shift_reg;
  logic              readout_reg;
  logic [15:0]       osc_div_reg;
  logic [15:0]       osc_cnt_reg;
  logic              osc_tick_reg;
  logic [31:0]       low_cnt_reg;
  logic              armed_reg;
  logic              init_stb_reg;
  logic [31:0]       busy_cnt_reg;
  logic [7:0]        position_counter;
  mem_target_t       target_reg;
  logic              entry_inc_reg;
  logic              shift_on_reg;
  logic              scan_en_reg;
  logic [3:0]        disp_shift_reg;
  logic [7:0]        char_code_memory [CHAR_CELLS];
  logic [ICON_W-1:0] icon_memory [CHAR_CELLS];
  logic [ICON_W-1:0] glyph_memory [GLYPH_DEPTH];
  logic [7:0]        key_code;
  logic              exec;
  logic [7:0]        pos_step;
  logic              setup_ph;
  logic              access_ph;

  // Every pin from the host side crosses into core_clk here
  sync2 #(
    .W (10)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        ({link_clk, link_sel_n, link_data_in, reset_pin_n,
                mode_select_upper, mode_select_lower, key_return_lines}),
    .q        (sync_q)
  );

  assign {lclk_s, sel_n_s, din_s, rpin_s, ms_s, ret_s} = sync_q;
  assign rise = lclk_s & ~lclk_d_reg;
  assign fall = ~lclk_s & lclk_d_reg;
  // Busy refuses new words; host keeps the timing anyway
  assign exec = word_stb_reg & ~busy_flag & ~armed_reg;
  assign pos_step = dr_inc(entry_inc_reg);
  assign setup_ph = psel & ~penable & ~pready;
  assign access_ph = psel & penable & pready;

  function automatic logic [7:0] dr_inc(input logic inc);
    dr_inc = inc ? 8'h01 : 8'hFF;
  endfunction

  // Link clock edge finder, fed by the second synchroniser stage
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      lclk_d_reg <= 1'b0;
    else
      lclk_d_reg <= lclk_s;

  // Oscillator stand-in: one-cycle tick every osc_div_reg cycles
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      osc_cnt_reg <= '0;
      osc_tick_reg <= 1'b0;
    end
    else
    begin
      osc_tick_reg <= osc_cnt_reg == 16'h0000;
      osc_cnt_reg <= (osc_cnt_reg == 16'h0000) ? osc_div_reg - 16'h0001 : osc_cnt_reg - 16'h0001;
    end

  // Receive: MSB first on rising edges, split into two holding bytes
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      rx_shift_reg <= '0;
      bit_cnt_reg <= '0;
      word_stb_reg <= 1'b0;
      instruction_holding_reg <= 8'h00;
      data_holding_reg <= 8'h00;
    end
    else
    begin
      word_stb_reg <= 1'b0;
      if (sel_n_s)
        bit_cnt_reg <= '0;
      else if (rise && !readout_reg)
      begin
        rx_shift_reg <= {rx_shift_reg[13:0], din_s};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (bit_cnt_reg == 4'hF)
        begin
          instruction_holding_reg <= rx_shift_reg[14:7];
          data_holding_reg <= {rx_shift_reg[6:0], din_s};
          word_stb_reg <= 1'b1;
        end
      end
    end

  // Key reply goes out on falling edges until the select is released
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      tx_shift_reg <= '0;
      readout_reg <= 1'b0;
      link_data_out <= 1'b0;
      link_data_oe <= 1'b0;
    end
    else
    begin
      link_data_oe <= readout_reg & ~sel_n_s;
      if (sel_n_s)
        readout_reg <= 1'b0;
      else if (exec && instruction_holding_reg == OP_KEYREAD)
      begin
        tx_shift_reg <= {ms_s, KEY_FIXED, key_code};
        readout_reg <= 1'b1;
      end
      else if (fall && readout_reg)
      begin
        link_data_out <= tx_shift_reg[15];
        tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
      end
    end

  // Reset pin: a long enough low arms a reset of control state and characters at release
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      low_cnt_reg <= '0;
      armed_reg <= 1'b0;
      init_stb_reg <= 1'b0;
    end
    else
    begin
      init_stb_reg <= 1'b0;
      if (!rpin_s)
      begin
        if (low_cnt_reg < 32'(RSTLOW_CYCLES))
          low_cnt_reg <= low_cnt_reg + 32'h1;
        else
          armed_reg <= 1'b1;
      end
      else
      begin
        low_cnt_reg <= '0;
        armed_reg <= 1'b0;
        init_stb_reg <= armed_reg;
      end
    end

  // Busy flag: power-up, reset release, clear and memory write
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      busy_cnt_reg <= 32'(PWRUP_CYCLES);
      busy_flag <= 1'b1;
    end
    else if (armed_reg)
      busy_flag <= 1'b1;
    else if (init_stb_reg)
    begin
      busy_cnt_reg <= 32'(RSTBUSY_CYCLES);
      busy_flag <= 1'b1;
    end
    else if (exec && instruction_holding_reg == OP_CLEAR)
    begin
      busy_cnt_reg <= 32'(CLEAR_CYCLES);
      busy_flag <= 1'b1;
    end
    else if (exec && instruction_holding_reg == OP_WRITE)
    begin
      busy_cnt_reg <= 32'(WRITE_CYCLES);
      busy_flag <= 1'b1;
    end
    else if (busy_cnt_reg > 32'h1)
      busy_cnt_reg <= busy_cnt_reg - 32'h1;
    else
    begin
      busy_cnt_reg <= '0;
      busy_flag <= 1'b0;
    end

  // Control state set by instructions; unused operand bits never read
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      position_counter <= HOME_POS;
      target_reg <= TGT_CHAR;
      entry_inc_reg <= 1'b1;
      shift_on_reg <= 1'b0;
      scan_en_reg <= 1'b0;
      disp_shift_reg <= '0;
      static_port <= 4'h0;
      contrast_level <= 4'h0;
      display_on <= 1'b0;
      icon_on <= 1'b0;
      blink_on <= 1'b0;
      power_down <= 1'b0;
    end
    else if (init_stb_reg)
    begin
      position_counter <= HOME_POS;
      target_reg <= TGT_CHAR;
      entry_inc_reg <= 1'b1;
      shift_on_reg <= 1'b0;
      scan_en_reg <= 1'b0;
      disp_shift_reg <= '0;
      static_port <= 4'h0;
      contrast_level <= 4'h0;
      display_on <= 1'b0;
      icon_on <= 1'b0;
      blink_on <= 1'b0;
      power_down <= 1'b0;
    end
    else if (exec)
      case (instruction_holding_reg)
        OP_CLEAR:
        begin
          position_counter <= HOME_POS;
          target_reg <= TGT_CHAR;
          entry_inc_reg <= 1'b1;
        end
        OP_HOME:
        begin
          position_counter <= HOME_POS;
          target_reg <= TGT_CHAR;
          disp_shift_reg <= '0;
        end
        OP_ENTRY:
        begin
          entry_inc_reg <= data_holding_reg[1];
          shift_on_reg <= data_holding_reg[0];
        end
        OP_DISP:
        begin
          display_on <= data_holding_reg[2];
          icon_on <= data_holding_reg[1];
          blink_on <= data_holding_reg[0];
        end
        OP_ASHIFT:
          position_counter <= position_counter + dr_inc(data_holding_reg[0]);
        OP_DSHIFT:
          disp_shift_reg <= disp_shift_reg + (data_holding_reg[0] ? 4'hF : 4'h1);
        OP_PORT:
          static_port <= data_holding_reg[3:0];
        OP_CONTRAST:
          contrast_level <= data_holding_reg[3:0];
        OP_MODE:
        begin
          scan_en_reg <= data_holding_reg[1];
          power_down <= data_holding_reg[0];
        end
        OP_DDMK:
        begin
          position_counter <= {3'b000, data_holding_reg[4:0]};
          target_reg <= data_holding_reg[ICON_BIT] ? TGT_ICON : TGT_CHAR;
        end
        OP_GLYPH:
        begin
          position_counter <= data_holding_reg;
          target_reg <= TGT_GLYPH;
        end
        OP_WRITE:
        begin
          position_counter <= position_counter + pos_step;
          // Only character writes move the display
          if (shift_on_reg && target_reg == TGT_CHAR)
            disp_shift_reg <= disp_shift_reg + (entry_inc_reg ? 4'h1 : 4'hF);
        end
        default:
          position_counter <= position_counter; // Test code and others
      endcase

  // Display memories; clear and init fill characters with spaces
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      for (int i = 0; i < CHAR_CELLS; i++)
      begin
        char_code_memory[i] <= SPACE_CODE;
        icon_memory[i] <= '0;
      end
      for (int g = 0; g < GLYPH_DEPTH; g++)
        glyph_memory[g] <= '0;
    end
    else if (init_stb_reg || (exec && instruction_holding_reg == OP_CLEAR))
    begin
      for (int i = 0; i < CHAR_CELLS; i++)
        char_code_memory[i] <= SPACE_CODE;
    end
    else if (exec && instruction_holding_reg == OP_WRITE && position_counter[3:0] < 4'(CHAR_CELLS))
      case (target_reg)
        TGT_CHAR:
          char_code_memory[position_counter[3:0]] <= data_holding_reg;
        TGT_ICON:
          icon_memory[position_counter[3:0]] <= data_holding_reg[ICON_W-1:0];
        default:
          glyph_memory[position_counter] <= data_holding_reg[ICON_W-1:0];
      endcase
    else if (exec && instruction_holding_reg == OP_WRITE && target_reg == TGT_GLYPH)
      glyph_memory[position_counter] <= data_holding_reg[ICON_W-1:0];

  // Key matrix scanner; power down disables scanning while windows keep running
  key_scanner u_scan (
    .core_clk      (core_clk),
    .rst           (rst),
    .osc_tick      (osc_tick_reg),
    .scan_en       (scan_en_reg & ~power_down),
    .hold          (readout_reg),
    .ret_sync      (ret_s),
    .scan_window   (scan_window),
    .scan_drive_n  (shared_scan_segment_outputs),
    .pullup_en     (key_pullup_en),
    .all_nonselect (all_segments_nonselect),
    .key_code      (key_code),
    .key_pending   (key_pending)
  );

  // APB slave: answer in the cycle after setup, write at that edge
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
      osc_div_reg <= OSC_DIV;
    end
    else
    begin
      pready <= setup_ph;
      // Error flag stands only in its ready cycle, never into the next transfer
      pslverr <= 1'b0;
      if (setup_ph)
      begin
        prdata <= '0;
        case (paddr)
          REG_STATUS:
            prdata <= {12'h000, disp_shift_reg, readout_reg, key_pending, busy_flag,
                       scan_en_reg, entry_inc_reg, shift_on_reg, target_reg, position_counter};
          REG_KEY:
            prdata <= {16'h0, ms_s, KEY_FIXED, key_code};
          REG_OSCDIV:
            prdata <= {16'h0, osc_div_reg};
          REG_SETUP:
            prdata <= {20'h0, contrast_level, static_port, power_down, display_on, icon_on, blink_on};
          default:
            pslverr <= 1'b1;
        endcase
      end
      // Zero divider would slow the tick to one every 65536 cycles; such writes are dropped
      if (access_ph && pwrite && paddr == REG_OSCDIV && pwdata[15:0] != 16'h0000)
        osc_div_reg <= pwdata[15:0];
    end
endmodule

// [verif/lcd_keyscan_props.sv]
// Port checks of the display command and key scan top
module lcd_keyscan_props (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       reset_pin_n,
  input wire logic       busy_flag,
  input wire logic [7:0] shared_scan_segment_outputs,
  input wire logic       key_pullup_en,
  input wire logic       scan_window,
  input wire logic       all_segments_nonselect
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Busy must persist after any reset, not merely appear for a cycle
  sequence s_busy8;
    busy_flag [*8];
  endsequence
  a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready) else $error("apb answer late or long");
  a_err_ready: assert property (pslverr |-> pready) else $error("error flag without ready");
  a_power_busy: assert property ($fell(rst) |-> s_busy8) else $error("busy missing after reset");
  a_pin_busy: assert property ($rose(reset_pin_n) && busy_flag |=> s_busy8)
    else $error("busy missing after pin reset");
  a_scan_gap: assert property (shared_scan_segment_outputs != 8'hFF |-> scan_window)
    else $error("scan pulse outside window");
  a_one_line: assert property ($onehot0(~shared_scan_segment_outputs)) else $error("two scan lines low");
  a_pullup_on: assert property (key_pullup_en |-> scan_window && !all_segments_nonselect)
    else $error("pull-up outside scan window");
  a_off_quiet: assert property (all_segments_nonselect |-> scan_window && !key_pullup_en
    && shared_scan_segment_outputs == 8'hFF) else $error("scan activity with scanning off");
endmodule
bind lcd_command_keyscan lcd_keyscan_props u_props (.core_clk, .rst, .psel, .penable, .pready, .pslverr,
  .reset_pin_n, .busy_flag, .shared_scan_segment_outputs, .key_pullup_en, .scan_window, .all_segments_nonselect);

// [verif/link_host.sv]
// Host side model of the serial instruction link
module link_host (
  output logic      link_clk,
  output logic      link_sel_n,
  output logic      link_data_in,
  input  wire logic link_data_out,
  input  wire logic link_data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clock rests high and select stays off between frames
  initial {link_clk, link_sel_n, link_data_in} = 3'b110;
  // Data changes on falling edges, MSB first; reply bits are taken on rising edges
  task automatic xfer(input logic [15:0] w, input logic rd, output logic [15:0] r);
    // Pins change by NBA on core clock edges, so the synchroniser never races them
    r = 16'h0000;
    link_sel_n <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      #32 link_clk <= 1'b0;
      link_data_in <= w[i];
      #32 link_clk <= 1'b1;
    end
    #32 link_data_in <= ~w[0]; // A released line must not keep a stale bit
    for (int i = 15; rd && i >= 0; i--)
    begin
      #32 link_clk <= 1'b0;
      #32 link_clk <= 1'b1;
      r[i] = link_data_oe ? link_data_out : 1'bx;
    end
    #64 link_sel_n <= 1'b1;
  endtask
endmodule

// [verif/lcd_command_keyscan_tb.sv]
// Self-checking bench of the display command and key scan block
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module lcd_command_keyscan_tb
  import lcd_keyscan_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, reset_pin_n = 1'b1;
  logic        key_on = 1'b0, pready, pslverr, e, link_clk, link_sel_n, link_data_in, link_data_out, link_data_oe;
  logic        busy_flag, key_pending, display_on, key_pullup_en, all_segments_nonselect;
  logic        ms_hi = 1'b1, ms_lo = 1'b0;
  logic [3:0]  static_port, contrast_level;
  logic [7:0]  shared_scan_segment_outputs;
  logic [11:0] paddr = 12'h000;
  logic [15:0] r;
  logic [31:0] pwdata = 32'h0, prdata, q;
  int          error_cnt = 0, n_checks = 0, n, n_pu = 0, n_ns = 0;
  // Words that walk the position counter, with the position expected after each
  logic [15:0] op [8] = '{16'h9303, 16'h9841, 16'h8800, 16'h9841, 16'h9201, 16'h9999, 16'h9841, 16'h9100};
  logic [7:0]  ps [8] = '{8'h03, 8'h04, 8'h04, 8'h03, 8'h04, 8'h00, 8'h01, 8'h00};
  // One key at return 2 and scan line 2: its return follows that line while held
  wire  [3:0]  key_return_lines = {1'b1, key_on ? shared_scan_segment_outputs[2] : 1'b1, 2'b11};
  always #4 core_clk = ~core_clk;
  // Cycles with pull-up or nonselect show which scan mode really ran
  always @(posedge core_clk)
  begin
    n_pu <= n_pu + int'(key_pullup_en);
    n_ns <= n_ns + int'(all_segments_nonselect);
  end
  link_host host (.link_clk, .link_sel_n, .link_data_in, .link_data_out, .link_data_oe);
  lcd_command_keyscan #(.PWRUP_CYCLES(200), .RSTLOW_CYCLES(100), .RSTBUSY_CYCLES(100), .CLEAR_CYCLES(50),
    .WRITE_CYCLES(20)) DUT (.core_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .link_clk, .link_sel_n, .link_data_in, .link_data_out, .link_data_oe, .reset_pin_n,
    .mode_select_upper(ms_hi), .mode_select_lower(ms_lo), .key_return_lines, .busy_flag, .key_pending,
    .shared_scan_segment_outputs, .key_pullup_en, .scan_window(), .all_segments_nonselect, .static_port,
    .contrast_level, .display_on, .icon_on(), .blink_on(), .power_down());
  // One APB transfer: setup, then access held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1 && ++k < 20);
    if (pready !== 1'b1) error_cnt++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Send one word; 60 cycles covers the longest execute time of 50
  task automatic word(input logic [15:0] w);
    host.xfer(w, 1'b0, r); // Only defined opcodes, never all-zero words
    repeat (60) @(posedge core_clk);
  endtask
  // Bounded wait for a flag level; n holds the cycles it took
  task automatic wait_lvl(input logic pend, input logic v);
    for (n = 0; (pend ? key_pending : busy_flag) !== v && n < 3000; n++) @(posedge core_clk);
    if (n >= 3000) error_cnt++;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    wait_lvl(1'b0, 1'b0);
    `CHK("power-up busy span", 1'b1, n >= 199)
    apb(1'b1, REG_OSCDIV, 32'h4);
    apb(1'b1, REG_OSCDIV, 32'h0);
    apb(1'b0, REG_OSCDIV, 32'h0);
    `CHK("oscdiv", 16'h0004, q[15:0])
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped", 33'h100000000, {e, q})
    $display("test power-up and registers done");
    word(16'h8CF5);
    word(16'h8BFA);
    word(16'h89F7);
    apb(1'b0, REG_SETUP, 32'h0);
    `CHK("setup", 12'h5A7, q[11:0])
    `CHK("port pins", 8'h5A, {contrast_level, static_port})
    for (int i = 0; i < 8; i++)
    begin
      word(op[i]);
      apb(1'b0, REG_STATUS, 32'h0);
      `CHK("position", ps[i], q[7:0])
    end
    word(16'h8803);
    word(16'h9841);
    word(16'h9010);
    word(16'h9841);
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK("shift and glyph", 20'h10F11, q[19:0])
    $display("test instructions done");
    `CHK("scan off quiet", 2'b01, {n_pu != 0, n_ns != 0})
    word(16'h8E02);
    key_on <= 1'b1;
    wait_lvl(1'b1, 1'b1);
    `CHK("key pending", 1'b1, key_pending)
    `CHK("scan on pull-up", 1'b1, n_pu != 0)
    host.xfer(16'hA700, 1'b1, r);
    `CHK("key reply", 16'hA742, r)
    apb(1'b0, REG_KEY, 32'h0);
    `CHK("key register", 32'h0000A742, q)
    key_on <= 1'b0;
    ms_hi <= 1'b0;
    ms_lo <= 1'b1;
    wait_lvl(1'b1, 1'b0);
    apb(1'b0, REG_KEY, 32'h0);
    `CHK("key released", 32'h00006700, q)
    $display("test key scan done");
    reset_pin_n <= 1'b0;
    repeat (120) @(posedge core_clk);
    reset_pin_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    wait_lvl(1'b0, 1'b0);
    `CHK("pin busy span", 1'b1, n >= 90)
    `CHK("display after pin reset", 1'b0, display_on)
    $display("test reset pin done");
    report_and_stop();
  end
  // Tests take about 40 us; this limit leaves ample margin
  initial
  begin
    #300us;
    error_cnt++;
    report_and_stop();
  end
endmodule
